/* sbt_defs.vh */
// Register offsets, field positions, reset values and timing counts of the bus timing block.
`ifndef SBT_DEFS_VH
`define SBT_DEFS_VH
`define SBT_CFG_ADDR 8'hC1
`define SBT_CFG_RESET 8'h00
`define SBT_BIT_ENABLE 7
`define SBT_BIT_INHIBIT 6
`define SBT_BIT_BUSY 5
`define SBT_BIT_EXTEND 4
`define SBT_BIT_LOW_TO 3
`define SBT_BIT_FREE_TO 2
`define SBT_BIT_CS_HI 1
`define SBT_BIT_CS_LO 0
`define SBT_WRITE_MASK 8'hDF
`define SBT_SETUP_EXT 8'h0B
`define SBT_HOLD_EXT 8'h0C
`define SBT_HOLD_BASE 8'h03
`define SBT_SETUP_MARGIN 8'h04
`define SBT_SETUP_SW 8'h01
`define SBT_FREE_PERIODS 4'hA
`define SBT_LOW_PHASE 2'h1
`define SBT_HIGH_PHASE 2'h2
`endif

/* sbt_sync.v */
// Two-flop synchroniser for one signal arriving from outside the system clock domain.
`timescale 1ns/100ps
`default_nettype none
module sbt_sync
(
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire async_in,
	output reg sync_out
);
	reg meta_r;

	// The first stage feeds only the second; bus lines idle high, so both reset to one.
	always @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_r <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* sbt_timing.v */
// Bus timing and configuration: master clock pacing, SDA setup/hold, timeouts, config register.
//
// Summary of operation
// R1: Undisturbed master clock high phase lasts about twice the low phase.
// R2: Master never makes SCL phases shorter than one source overflow period.
// R3: Master waits while SCL is held low by others before continuing.
// R4: With extension on, SDA setup is 11 clocks and hold 12 clocks.
// R5: Without extension, hold is 3 clocks; setup is low time minus 4.
// R6: Short software-delay setup applies only to ACK bits and data MSBs.
// R7: Software delay runs from data/ACK write until the interrupt flag clears.
// R8: Software picks extension so setup reaches 250 ns and hold 300 ns.
// R9: Software should enable extension when the system clock exceeds 10 MHz.
// R10: Low-timeout enabled: third timer reloads while SCL high, counts while low.
// R11: Software sets third timer to 25 ms and restarts the interface on overflow.
// R12: Free-timeout enabled: bus free once both lines high over 10 periods.
// R13: A bus-free timeout acts like a stop: interrupt request and stop flag.
// R14: Bit 7 enables the interface; enabled, it watches the bus lines.
// R15: Slave inhibit NACKs addresses and mutes slave interrupts from next start.
// R16: Clock select 00,01,10,11 picks timer0, timer1, timer4 high, timer4 low overflows.
// R17: Minimum SCL low and high times each equal one source overflow period.
// R18: Undisturbed master bit rate is one third of the overflow rate.
// R19: Busy bit sets during a transfer and clears on stop or free timeout.
// R20: All configuration bits reset to zero.
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defs.vh"
module sbt_timing
(
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire [7:0] sfr_wdata_in,
	output reg [7:0] sfr_rdata_out,
	input wire ovf_timer0_in,
	input wire ovf_timer1_in,
	input wire ovf_timer4_hi_in,
	input wire ovf_timer4_lo_in,
	input wire master_run_in,
	input wire sda_next_in,
	input wire sda_next_valid_in,
	input wire short_setup_in,
	input wire sw_release_in,
	input wire scl_in,
	input wire sda_in,
	output reg scl_oe_out,
	output reg sda_oe_out,
	output wire scl_out,
	output wire sda_out,
	output reg timer3_reload_out,
	output reg stop_detect_out,
	output reg free_timeout_out,
	output reg bit_done_out,
	output reg slave_inhibit_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Configuration register.
	reg [7:0] cfg_r;
	reg busy_r;
	reg inh_pending_r;
	wire scl_s;
	wire sda_s;
	reg scl_d_r;
	reg sda_d_r;
	wire enable = cfg_r[`SBT_BIT_ENABLE];
	wire start_seen = enable && scl_s && scl_d_r && sda_d_r && !sda_s;
	wire stop_seen = enable && scl_s && scl_d_r && !sda_d_r && sda_s;

	// Open-drain lines only ever drive low; the enables decide the level.
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	sbt_sync u_scl_sync
	(
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.async_in(scl_in),
		.sync_out(scl_s)
	);

	sbt_sync u_sda_sync
	(
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.async_in(sda_in),
		.sync_out(sda_s)
	);

	// Writes store every bit but busy, which only hardware drives.
	always @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cfg_r <= `SBT_CFG_RESET; // see R20
		else if (sfr_wr_in && sfr_addr_in == `SBT_CFG_ADDR)
			cfg_r <= sfr_wdata_in & `SBT_WRITE_MASK; // see R14
	end

	// Reads return live busy state; other addresses read as zero.
	always @*
	begin
		sfr_rdata_out = 8'h00;
		if (sfr_addr_in == `SBT_CFG_ADDR)
		begin
			sfr_rdata_out = cfg_r;
			sfr_rdata_out[`SBT_BIT_BUSY] = busy_r; // see R19
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock source selection.
	reg src_ovf;

	always @*
	begin
		case ({cfg_r[`SBT_BIT_CS_HI], cfg_r[`SBT_BIT_CS_LO]}) // see R16
		2'b00: src_ovf = ovf_timer0_in;
		2'b01: src_ovf = ovf_timer1_in;
		2'b10: src_ovf = ovf_timer4_hi_in;
		default: src_ovf = ovf_timer4_lo_in;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus monitor: edges, busy, inhibit, low timeout and free timeout.
	reg [3:0] free_cnt_r;

	// Busy and the inhibit take-over are set by the start; a stop or free timeout clears busy only.
	always @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			busy_r <= 1'b0;
			slave_inhibit_out <= 1'b0;
			inh_pending_r <= 1'b0;
			free_cnt_r <= 4'h0;
			free_timeout_out <= 1'b0;
			stop_detect_out <= 1'b0;
			timer3_reload_out <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			inh_pending_r <= cfg_r[`SBT_BIT_INHIBIT];
			free_timeout_out <= 1'b0;
			stop_detect_out <= 1'b0;
			// A low SCL lets the third timer run; high or disabled keeps it reloading.
			timer3_reload_out <= !(enable && cfg_r[`SBT_BIT_LOW_TO] && !scl_s); // see R10
			if (start_seen)
				slave_inhibit_out <= inh_pending_r; // see R15
			if (!enable)
				busy_r <= 1'b0;
			else if (start_seen)
				busy_r <= 1'b1; // see R19
			else if (stop_seen || free_timeout_out)
				busy_r <= 1'b0; // see R19
			// Counting source periods with both lines high; the eleventh overflow crosses ten.
			if (!enable || !cfg_r[`SBT_BIT_FREE_TO] || !scl_s || !sda_s || !busy_r)
				free_cnt_r <= 4'h0;
			else if (src_ovf)
			begin
				if (free_cnt_r == `SBT_FREE_PERIODS)
				begin
					free_cnt_r <= 4'h0;
					free_timeout_out <= 1'b1; // see R12
				end
				else
					free_cnt_r <= free_cnt_r + 4'h1;
			end
			// The free timeout is reported exactly as a detected stop.
			stop_detect_out <= stop_seen || (free_timeout_out && busy_r); // see R13
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Master SCL generator: one period low, two periods high, stretched by the bus.
	localparam ST_IDLE = 3'b001;
	localparam ST_LOW = 3'b010;
	localparam ST_HIGH = 3'b100;
	reg [2:0] state_r;
	reg [1:0] ph_cnt_r;
	reg [7:0] low_cnt_r;
	reg [7:0] hold_cnt_r;
	reg sda_pend_r;
	reg sda_val_r;
	reg setup_ok;

	// Setup needed before releasing SCL, in system clocks spent low.
	function [7:0] sbt_need;
		input ext;
		input shortcut;
		input [7:0] low_len;
		begin
			if (ext)
				sbt_need = `SBT_SETUP_EXT; // see R4
			else if (shortcut)
				sbt_need = `SBT_SETUP_SW; // see R6
			else if (low_len > `SBT_SETUP_MARGIN)
				sbt_need = low_len - `SBT_SETUP_MARGIN; // see R5
			else
				sbt_need = 8'h01;
		end
	endfunction

	always @*
	begin
		setup_ok = low_cnt_r >= sbt_need(cfg_r[`SBT_BIT_EXTEND], short_setup_in, low_cnt_r);
	end

	// The low phase ends only after a source overflow; the high phase also ends early when another master pulls SCL low after its first overflow.
	always @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= ST_IDLE;
			ph_cnt_r <= 2'h0;
			low_cnt_r <= 8'h00;
			hold_cnt_r <= 8'h00;
			sda_pend_r <= 1'b0;
			sda_val_r <= 1'b1;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
			bit_done_out <= 1'b0;
		end
		else
		begin
			bit_done_out <= 1'b0;
			if (hold_cnt_r != 8'h00)
				hold_cnt_r <= hold_cnt_r - 8'h01;
			if (sda_next_valid_in)
			begin
				sda_pend_r <= 1'b1;
				sda_val_r <= sda_next_in;
				low_cnt_r <= 8'h00; // setup counted from data write, see R7
			end
			else if (low_cnt_r != 8'hFF)
				low_cnt_r <= low_cnt_r + 8'h01;
			// New data reaches SDA only once hold time after the falling edge is met.
			// Setup restarts when SDA really moves, so a long hold wait cannot eat into it.
			if (sda_pend_r && hold_cnt_r == 8'h00 && !sda_next_valid_in)
			begin
				sda_oe_out <= !sda_val_r;
				sda_pend_r <= 1'b0;
				low_cnt_r <= 8'h00; // see R4
			end
			case (state_r)
			ST_IDLE:
			begin
				scl_oe_out <= 1'b0;
				if (enable && master_run_in)
				begin
					state_r <= ST_LOW;
					scl_oe_out <= 1'b1;
					ph_cnt_r <= 2'h0;
					hold_cnt_r <= cfg_r[`SBT_BIT_EXTEND] ? `SBT_HOLD_EXT : `SBT_HOLD_BASE; // see R4 R5
				end
			end
			ST_LOW:
			begin
				if (src_ovf && ph_cnt_r != `SBT_LOW_PHASE)
					ph_cnt_r <= ph_cnt_r + 2'h1; // see R17
				// Release needs the low period, setup met, data applied and software done.
				if (ph_cnt_r == `SBT_LOW_PHASE && setup_ok && !sda_pend_r && sw_release_in)
				begin
					scl_oe_out <= 1'b0; // see R2
					state_r <= ST_HIGH;
					ph_cnt_r <= 2'h0;
				end
			end
			ST_HIGH:
			begin
				// High time counts only once SCL really reads high.
				if (!scl_s && scl_oe_out == 1'b0 && ph_cnt_r == 2'h0)
					ph_cnt_r <= 2'h0; // see R3
				else if (!scl_s)
				begin
					// Another master pulled SCL low early: follow it into the low phase.
					state_r <= ST_LOW;
					scl_oe_out <= 1'b1;
					ph_cnt_r <= 2'h0;
					bit_done_out <= 1'b1;
					hold_cnt_r <= cfg_r[`SBT_BIT_EXTEND] ? `SBT_HOLD_EXT : `SBT_HOLD_BASE;
				end
				else if (src_ovf)
				begin
					if (ph_cnt_r == `SBT_HIGH_PHASE - 2'h1) // two periods high, see R1 R18
					begin
						bit_done_out <= 1'b1;
						ph_cnt_r <= 2'h0;
						hold_cnt_r <= cfg_r[`SBT_BIT_EXTEND] ? `SBT_HOLD_EXT : `SBT_HOLD_BASE;
						if (enable && master_run_in)
						begin
							state_r <= ST_LOW;
							scl_oe_out <= 1'b1;
						end
						else
							state_r <= ST_IDLE;
					end
					else
						ph_cnt_r <= ph_cnt_r + 2'h1;
				end
			end
			default:
				state_r <= ST_IDLE;
			endcase
			if (!enable)
			begin
				state_r <= ST_IDLE;
				scl_oe_out <= 1'b0;
				sda_oe_out <= 1'b0;
				sda_pend_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* sbt_timing_asserts.sv */
// Concurrent checks on the ports of the bus timing block.
`timescale 1ns/100ps
`default_nettype none
module sbt_timing_asserts
(
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire [7:0] sfr_wdata_in,
	input wire [7:0] sfr_rdata_out,
	input wire ovf_timer0_in,
	input wire ovf_timer1_in,
	input wire ovf_timer4_hi_in,
	input wire ovf_timer4_lo_in,
	input wire master_run_in,
	input wire scl_in,
	input wire sda_in,
	input wire scl_oe_out,
	input wire sda_oe_out,
	input wire timer3_reload_out,
	input wire free_timeout_out
);
reg [7:0] cfg_r, lo_r, hi_r, fall_r, chg_r, idle_r;
reg sda_q_r;
wire [3:0] ovf_all = {ovf_timer4_lo_in, ovf_timer4_hi_in, ovf_timer1_in, ovf_timer0_in};
wire ovf = ovf_all[cfg_r[1:0]];
wire lto = cfg_r[7] & cfg_r[3];
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!rst_n_in);
////////////////////////////////////////
// Ages other than lo_r saturate, so a long idle bus never wraps into a false pass.
always @(posedge clk_sys_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		cfg_r <= 8'h00;
		lo_r <= 8'h00;
		hi_r <= 8'h02;
		fall_r <= 8'h00;
		chg_r <= 8'hFF;
		idle_r <= 8'h00;
		sda_q_r <= 1'b0;
	end
	else
	begin
		if (sfr_wr_in && sfr_addr_in == 8'hC1)
			cfg_r <= sfr_wdata_in & 8'hDF;
		lo_r <= scl_oe_out ? lo_r + {7'h00, ovf} : 8'h00;
		hi_r <= !master_run_in ? 8'h02 : scl_oe_out ? 8'h00 :
			hi_r + {7'h00, ovf & scl_in & ~hi_r[1]};
		fall_r <= scl_oe_out ? fall_r + {7'h00, ~&fall_r} : 8'h00;
		chg_r <= (sda_oe_out != sda_q_r) ? 8'h01 : chg_r + {7'h00, ~&chg_r};
		idle_r <= (scl_in & sda_in) ? idle_r + {7'h00, ovf & ~&idle_r} : 8'h00;
		sda_q_r <= sda_oe_out;
	end
end
// The master lets SCL rise at the end of its low phase.
sequence phase_end_s;
	master_run_in && $fell(scl_oe_out);
endsequence
cfg_write_a: assert property (sfr_wr_in && sfr_addr_in == 8'hC1 ##1
	sfr_addr_in == 8'hC1 |-> (sfr_rdata_out & 8'hDF) == ($past(sfr_wdata_in) & 8'hDF))
	else $error("config readback wrong");
unmapped_read_a: assert property (sfr_addr_in != 8'hC1 |-> sfr_rdata_out == 8'h00)
	else $error("unmapped read not zero");
reload_high_a: assert property ((lto && scl_in) [*6] |-> timer3_reload_out)
	else $error("timer not reloaded");
reload_low_a: assert property ((lto && !scl_in) [*6] |-> !timer3_reload_out)
	else $error("timer held in reload");
low_phase_a: assert property (phase_end_s |-> lo_r >= 8'h01)
	else $error("low phase too short");
high_phase_a: assert property (master_run_in && $rose(scl_oe_out) |-> hi_r >= 8'h02)
	else $error("high phase too short");
hold_time_a: assert property (master_run_in && scl_oe_out && $changed(sda_oe_out)
	|-> fall_r >= (cfg_r[4] ? 8'h0C : 8'h03))
	else $error("data hold too short");
setup_time_a: assert property (phase_end_s and cfg_r[4] |-> chg_r >= 8'h0B)
	else $error("data setup too short");
free_quiet_a: assert property (free_timeout_out |-> cfg_r[2] && idle_r >= 8'h0A)
	else $error("free timeout too early");
endmodule
bind sbt_timing sbt_timing_asserts chk (.*);
`default_nettype wire

/* sbt_bus_peer.sv */
// Far-side bus device that can stretch SCL low after each falling edge.
`timescale 1ns/100ps
`default_nettype none
module sbt_bus_peer
(
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic stretch_in,
	output logic scl_pull_out
);
logic scl_q = 1'b1;
logic [3:0] hold_r = 4'h0;
// A slow device holds SCL eight of its clocks; a prompt one never holds it.
always @(posedge link_clk_in)
begin
	scl_q <= scl_in;
	if (scl_q && !scl_in && stretch_in)
		hold_r <= 4'h8;
	else if (hold_r != 4'h0)
		hold_r <= hold_r - 4'h1;
end
assign scl_pull_out = hold_r != 4'h0;
endmodule
`default_nettype wire

/* test_smbus_timing_config.sv */
// Self-checking bench for the bus timing and configuration block.
`timescale 1ns/100ps
`default_nettype none
module test_smbus_timing_config;
reg clk = 0, lclk = 0, rst_n = 0, wr = 0, run = 0, sdn = 0, sdv = 0, shs = 0;
reg pull = 0, tscl = 0, stretch = 0;
reg [7:0] addr = 8'hC1, wd = 8'h00, d;
reg [3:0] ovf = 4'h0, mask = 4'h0;
reg [31:0] seed = 32'h38BB80C4;
integer errors = 0, check_count = 0, cyc = 0, bits = 0, frees = 0, stops = 0, n, k, cs;
wire [7:0] rd;
wire scl_oe, sda_oe, bd, fto, stp, ppull, slave_inhibit;
wire scl = !(scl_oe | ppull | tscl);
wire sda = !(sda_oe | pull);
sbt_timing uut (.clk_sys_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
	.sfr_wdata_in(wd), .sfr_rdata_out(rd), .ovf_timer0_in(ovf[0]), .ovf_timer1_in(ovf[1]),
	.ovf_timer4_hi_in(ovf[2]), .ovf_timer4_lo_in(ovf[3]), .master_run_in(run),
	.sda_next_in(sdn), .sda_next_valid_in(sdv), .short_setup_in(shs), .sw_release_in(1'b1),
	.scl_in(scl), .sda_in(sda), .scl_oe_out(scl_oe), .sda_oe_out(sda_oe), .scl_out(),
	.sda_out(), .timer3_reload_out(), .stop_detect_out(stp), .free_timeout_out(fto),
	.bit_done_out(bd), .slave_inhibit_out(slave_inhibit));
sbt_bus_peer peer (.link_clk_in(lclk), .scl_in(scl), .stretch_in(stretch),
	.scl_pull_out(ppull));
////////////////////////////////////////
function [31:0] xs(input [31:0] s);
reg [31:0] t;
begin
	t = s ^ (s << 13);
	t = t ^ (t >> 17);
	xs = t ^ (t << 5);
end
endfunction
// Bit 5 is status, so a write never lands there.
function [7:0] cfg_exp(input [7:0] v);
	cfg_exp = v & 8'hDF;
endfunction
task step;
begin
	@(posedge clk);
	#1;
end
endtask
task wreg(input [7:0] a, input [7:0] v);
begin
	addr = a;
	wd = v;
	wr = 1;
	step;
	wr = 0;
	addr = 8'hC1;
	#1;
end
endtask
task chk(input [8*10:1] nm, input integer e, input integer g);
begin
	check_count = check_count + 1;
	if (g !== e)
	begin
		errors = errors + 1;
		$display("[ERR] %0s exp %0d got %0d", nm, e, g);
	end
end
endtask
task give_verdict;
begin
	$display("checks %0d errors %0d", check_count, errors);
	if (errors == 0 && check_count > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
end
endtask
////////////////////////////////////////
// The link clock is unrelated in phase to the system clock.
initial
begin
	#3.1;
	forever #62.5 lclk = ~lclk;
end
initial
begin
	forever #4 clk = ~clk;
end
// Count pulses, pace overflows, feed random bit data and cut a hang short.
always @(posedge clk)
begin
	cyc <= cyc + 1;
	bits <= bits + bd;
	frees <= frees + fto;
	stops <= stops + stp;
	ovf <= #1 (cyc % 10 == 0) ? mask : 4'h0;
	sdv <= #1 bd;
	if (bd)
		seed = xs(seed);
	sdn <= #1 seed[0];
	shs <= #1 seed[1];
	if (cyc == 5000)
	begin
		errors = errors + 1;
		give_verdict;
	end
end
initial
begin
	repeat (2) @(posedge clk);
	#1;
	rst_n = 1;
	chk("cfg_reset", 8'h00, rd);
	for (n = 0; n < 8; n = n + 1)
	begin
		seed = xs(seed);
		d = (n == 0) ? 8'hFF : seed[7:0];
		wreg(8'hC1, d);
		chk("cfg_write", cfg_exp(d), rd);
	end
	wreg(8'hC2, 8'hFF);
	chk("cfg_kept", cfg_exp(d), rd);
	addr = 8'hC2;
	#1;
	chk("unmapped", 8'h00, rd);
	for (cs = 0; cs < 4; cs = cs + 1)
	begin
		seed = xs(seed);
		// The slow peer only catches a long low phase, so its run uses extended setup.
		wreg(8'hC1, {3'b100, seed[4] | (cs == 3), 2'b11, cs[1:0]});
		stretch = cs == 3;
		mask = ~(4'h1 << cs);
		run = 1;
		k = bits;
		repeat (200) step;
		chk("no_clock", 0, bits - k);
		mask = 4'h1 << cs;
		k = bits;
		repeat (300) step;
		n = bits - k;
		chk("bit_rate", 1, stretch ? n < 4 : n > 5 && n < 11);
		run = 0;
		stretch = 0;
		mask = 4'h0;
		// Long enough for a peer hold of eight link clocks to run out.
		repeat (200) step;
	end
	wreg(8'hC1, 8'h00);
	wreg(8'hC1, 8'hC4);
	chk("inh_off", 0, slave_inhibit);
	repeat (5) step;
	pull = 1;
	repeat (5) step;
	tscl = 1;
	repeat (5) step;
	pull = 0;
	repeat (5) step;
	tscl = 0;
	repeat (5) step;
	chk("busy_set", 8'h20, rd & 8'h20);
	chk("inh_on", 1, slave_inhibit);
	k = frees;
	n = stops;
	mask = 4'h1;
	repeat (95) step;
	chk("free_early", 0, frees - k);
	repeat (40) step;
	chk("free_seen", 1, frees - k);
	chk("stop_seen", 1, stops - n);
	chk("busy_clear", 8'h00, rd & 8'h20);
	give_verdict;
end
endmodule
`default_nettype wire
